// >>> design/fault_id_regs.sv
// Purpose: aux fault status, core identity and cache identification registers
// Assumes: fault reports are pulses from logic on I_CLOCK; bus is classic Wishbone
// Notes:   every access is answered one cycle after it is seen, by ack or err
//
// How it works
// - fetch fault causes set their flag bits
// - bit 27 keeps fetch axi response kind
// - precise poison, gate, ecc causes set flags
// - bit 16 keeps precise axi response kind
// - precise fault interface flags bits 15..10
// - imprecise poison bit 9, ecc bit 7
// - bit 6 keeps imprecise axi response kind
// - imprecise fault interface flags bits 4..0
// - identity word read-only with five fields
// - cache level reads zero without caches
// - inner boundary field always reads zero
// - level fields one with both caches; a single cache gives one only with ZERO_LEVEL_IF_SINGLE low, else zero
// - first level cache kind encoding, rest zero
// - cache level read-only, privileged access only
// - select bit zero data, one instruction
// - select level field reads zero, ignores writes
// - select privileged only, one copy per security
// - size info follows select, zero if absent
// - cache type reads fixed constant value
// - fault flags reset zero, write one clears
// - fault groups valid only with their error; the bank keeps the flags regardless, the error qualifiers live outside
//
// Design decision made here: the Wishbone register port.
module fault_id_regs
  import fault_id_pkg::*;
#(
  parameter bit                    ICACHE_PRESENT       = 1'b1,
  parameter bit                    DCACHE_PRESENT       = 1'b1,
  parameter bit                    ZERO_LEVEL_IF_SINGLE = 1'b1,
  parameter logic [CSI_SETS_W-1:0] ICACHE_SETS          = 15'h00ff,
  parameter logic [CSI_SETS_W-1:0] DCACHE_SETS          = 15'h007f,
  parameter logic [7:0]            IMPLEMENTER_CODE     = 8'h5a,  // arbitrary value
  parameter logic [3:0]            VARIANT_CODE         = 4'h1,   // arbitrary value
  parameter logic [3:0]            ARCH_CODE            = 4'h7,   // arbitrary value
  parameter logic [11:0]           PART_NUMBER_CODE     = 12'h123, // arbitrary value
  parameter logic [3:0]            REVISION_CODE        = 4'h4    // arbitrary value
) (
  input  wire logic         I_CLOCK,
  input  wire logic         I_RST,
  input  wire logic         I_CE,
  input  wire wb_req_s      I_WB_REQ,
  input  wire logic         I_WB_PRIV,
  input  wire logic         I_WB_SECURE,
  input  wire fault_event_s I_FAULT_EVENT,
  output logic [31:0]       O_WB_DAT,
  output logic              O_WB_ACK,
  output logic              O_WB_ERR,
  output logic [31:0]       O_AUX_FAULT_STATUS
);

  // state: fault flags, two select copies,
  // the registered bus answer and the status mirror
  // everything else below is combinational
  logic [31:0] aux_fault_reg;
  logic [31:0] aux_fault_next;
  logic        select_secure_reg;
  logic        select_nonsecure_reg;
  logic        ack_reg;
  logic        err_reg;
  logic [31:0] rdata_reg;
  logic        access;
  logic        mapped;
  logic        priv_needed;
  logic        refuse;
  logic        do_write;
  logic [31:0] byte_mask;
  logic [31:0] wr_bits;
  logic [31:0] set_vec;
  logic [31:0] kind_load;
  logic [31:0] read_value;
  logic        cur_select;

  // bus side overview:
  // - one request is handled at a time
  // - the answer always comes one edge later
  // - a held request is taken again after
  //   the answer, so the master must drop it
  // - clock enable low freezes the answer too
  //
  // expand byte lane selects into a bit mask
  // sel gates lanes for writes only; reads
  // always return the full word
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{sel[i]}};
    end
    return m;
  endfunction : lane_mask

  // fault reports arrive as single cycle
  // pulses from logic on this clock, so no
  // synchroniser is placed in front of them;
  // a pulse from another domain would need
  // one outside this bank
  // map one cycle fault reports onto their status bit positions
  function automatic logic [31:0] fault_set_bits(input fault_event_s ev);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[BIT_FETCH_GATE] = ev.fetch_gate_violation;
    v[BIT_FETCH_ECC]  = ev.fetch_uncorrectable_error;
    v[BIT_FETCH_MAXI] = ev.fetch_main_axi_fault;
    v[BIT_FETCH_DTCM] = ev.fetch_data_tcm_fault;
    v[BIT_FETCH_ITCM] = ev.fetch_instr_tcm_fault;
    v[BIT_FETCH_KIND] = ev.fetch_main_axi_fault & ev.fetch_axi_resp_kind;
    v[BIT_PREC_POISON] = ev.precise_poisoned_read;
    v[BIT_PREC_GATE]   = ev.precise_gate_violation;
    v[BIT_PREC_ECC]    = ev.precise_uncorrectable_error;
    v[BIT_PREC_KIND] = ev.precise_main_axi_fault & ev.precise_axi_resp_kind;
    v[BIT_PREC_IPPB] = ev.precise_internal_periph_fault;
    v[BIT_PREC_EPPB] = ev.precise_external_periph_fault;
    v[BIT_PREC_MAXI] = ev.precise_main_axi_fault;
    v[BIT_PREC_PAHB] = ev.precise_periph_ahb_fault;
    v[BIT_PREC_DTCM] = ev.precise_data_tcm_fault;
    v[BIT_PREC_ITCM] = ev.precise_instr_tcm_fault;
    v[BIT_IMPR_POISON] = ev.imprecise_poisoned_read;
    v[BIT_IMPR_ECC]    = ev.imprecise_uncorrectable_error;
    v[BIT_IMPR_KIND] = ev.imprecise_main_axi_fault & ev.imprecise_axi_resp_kind;
    v[BIT_IMPR_EPPB] = ev.imprecise_external_periph_fault;
    v[BIT_IMPR_MAXI] = ev.imprecise_main_axi_fault;
    v[BIT_IMPR_PAHB] = ev.imprecise_periph_ahb_fault;
    v[BIT_IMPR_DTCM] = ev.imprecise_data_tcm_fault;
    v[BIT_IMPR_ITCM] = ev.imprecise_instr_tcm_fault;
    return v;
  endfunction : fault_set_bits

  // the level word is fixed at build time;
  // it folds to constants after elaboration
  // and costs no flip-flops
  // with ZERO_LEVEL_IF_SINGLE low a single
  // cache shows its own kind and level one
  // bits 20..3 and the boundary stay zero
  // cache level id from the build-time cache configuration
  function automatic logic [31:0] level_id_value(input logic ic, input logic dc);
    logic [31:0] v;
    logic [2:0]  lvl;
    v = 32'h0000_0000;
    lvl = (ic | dc) ? LEVEL_ONE : LEVEL_NONE;
    v[CLID_UU_LSB  +: 3] = lvl;
    v[CLID_COH_LSB +: 3] = lvl;
    v[CLID_UIS_LSB +: 3] = lvl;
    case ({ic, dc})
      2'h3:    v[2:0] = KIND_BOTH;
      2'h2:    v[2:0] = KIND_INSTR;
      2'h1:    v[2:0] = KIND_DATA;
      default: v[2:0] = KIND_NONE;
    endcase
    if (!(ic & dc) && ZERO_LEVEL_IF_SINGLE) begin
      v = 32'h0000_0000;
    end
    // inner boundary stays zero, bits 20..3 never set above
    return v;
  endfunction : level_id_value

  // size info layout, msb first:
  //   policy bits, set count, ways, line size
  // the set and way fields hold count minus one
  // size info word for one cache
  function automatic logic [31:0] size_info_word(input logic present,
                                                 input logic [CSI_SETS_W-1:0] sets,
                                                 input logic [9:0] assoc);
    return present ? {CSI_POLICY_BITS, sets, assoc, CSI_LINE_SIZE} : 32'h0000_0000;
  endfunction : size_info_word

  // decode: addresses must match in full,
  // so a misaligned or partial address is
  // answered with err rather than aliased
  // trade-off: a full compare costs a few
  // gates but keeps unused space quiet
  // the low two address bits must be zero
  // a new request is taken only while no answer is standing
  assign access   = I_WB_REQ.cyc & I_WB_REQ.stb & ~ack_reg & ~err_reg;
  assign mapped   = (I_WB_REQ.adr == ADDR_CORE_IDENTITY_BASE) |
                    (I_WB_REQ.adr == ADDR_AUX_FAULT_STATUS) |
                    (I_WB_REQ.adr == ADDR_CACHE_LEVEL_ID) |
                    (I_WB_REQ.adr == ADDR_CACHE_TYPE) |
                    (I_WB_REQ.adr == ADDR_CACHE_SIZE_INFO) |
                    (I_WB_REQ.adr == ADDR_CACHE_SIZE_SELECT);
  // identity and cache type stay open to any
  // privilege; the other words are refused
  // privileged only registers
  assign priv_needed = (I_WB_REQ.adr == ADDR_AUX_FAULT_STATUS) |
                       (I_WB_REQ.adr == ADDR_CACHE_LEVEL_ID) |
                       (I_WB_REQ.adr == ADDR_CACHE_SIZE_INFO) |
                       (I_WB_REQ.adr == ADDR_CACHE_SIZE_SELECT);
  assign refuse   = ~mapped | (priv_needed & ~I_WB_PRIV);
  assign do_write = access & I_WB_REQ.we & ~refuse;
  assign byte_mask = lane_mask(I_WB_REQ.sel);
  assign wr_bits   = I_WB_REQ.dat & byte_mask;

  // the select register is banked: secure and
  // non-secure software each keep their own
  // copy, so neither disturbs the other
  // select copy of the current security state
  assign cur_select = I_WB_SECURE ? select_secure_reg : select_nonsecure_reg;

  // limitation: a kind bit only tells the
  // response of the last main axi report of
  // its group; earlier ones are overwritten
  // kind bits are overwritten by a new main axi report, not just or-ed in
  assign set_vec   = fault_set_bits(I_FAULT_EVENT);
  always_comb begin
    kind_load = 32'h0000_0000;
    kind_load[BIT_FETCH_KIND] = I_FAULT_EVENT.fetch_main_axi_fault;
    kind_load[BIT_PREC_KIND]  = I_FAULT_EVENT.precise_main_axi_fault;
    kind_load[BIT_IMPR_KIND]  = I_FAULT_EVENT.imprecise_main_axi_fault;
  end

  // clear and set share one path so that a
  // fault arriving with a clear is never lost
  // the set wins, as the flags promise
  // write one clears; a report in the same cycle wins over the clear
  always_comb begin
    aux_fault_next = aux_fault_reg;
    if (do_write && (I_WB_REQ.adr == ADDR_AUX_FAULT_STATUS)) begin
      aux_fault_next = aux_fault_next & ~wr_bits;
    end
    aux_fault_next = (aux_fault_next & ~kind_load) | set_vec;
  end

  // clock enable low holds every flag
  // groups accumulate independently; the bus error flags that
  // qualify them live outside this bank, so the bits are kept as reported
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      aux_fault_reg <= AUX_FAULT_RESET;
    end else if (I_CE) begin
      aux_fault_reg <= aux_fault_next;
    end
  end

  // writes without lane zero leave the bit
  // untouched, matching byte wise stores
  // select bit written from lane zero only
  // level field has no storage, so writes to it vanish
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      select_secure_reg    <= SELECT_RESET;
      select_nonsecure_reg <= SELECT_RESET;
    end else if (I_CE) begin
      if (do_write && (I_WB_REQ.adr == ADDR_CACHE_SIZE_SELECT) && I_WB_REQ.sel[0]) begin
        if (I_WB_SECURE) begin
          select_secure_reg <= I_WB_REQ.dat[0];
        end else begin
          select_nonsecure_reg <= I_WB_REQ.dat[0];
        end
      end
    end
  end

  // reads decode the address every cycle;
  // only the value of the taking edge is
  // captured into the read data register
  // read multiplexer; writes to read-only words are acked and dropped
  always_comb begin
    read_value = 32'h0000_0000;
    case (I_WB_REQ.adr)
      ADDR_CORE_IDENTITY_BASE: read_value = {IMPLEMENTER_CODE, VARIANT_CODE, ARCH_CODE,
                                             PART_NUMBER_CODE, REVISION_CODE};
      ADDR_AUX_FAULT_STATUS:   read_value = aux_fault_reg;
      ADDR_CACHE_LEVEL_ID:     read_value = level_id_value(ICACHE_PRESENT, DCACHE_PRESENT);
      ADDR_CACHE_TYPE:         read_value = CACHE_TYPE_VALUE;
      ADDR_CACHE_SIZE_INFO:    read_value = cur_select ?
          size_info_word(ICACHE_PRESENT, ICACHE_SETS, CSI_ASSOC_INSTR) :
          size_info_word(DCACHE_PRESENT, DCACHE_SETS, CSI_ASSOC_DATA);
      ADDR_CACHE_SIZE_SELECT:  read_value = {31'h0000_0000, cur_select};
      default:                 read_value = 32'h0000_0000;
    endcase
  end

  // read data is zeroed between answers so a
  // stale word never shows on the bus
  // refused accesses change no state other than the err answer
  // one cycle answer; err for unmapped words and unprivileged access
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      ack_reg   <= 1'b0;
      err_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else if (I_CE) begin
      ack_reg   <= access & ~refuse;
      err_reg   <= access & refuse;
      if (access && !refuse && !I_WB_REQ.we) begin
        rdata_reg <= read_value;
      end else begin
        rdata_reg <= 32'h0000_0000; // data bus is quiet outside a read answer
      end
    end
  end

  // the mirror takes the next value, so it
  // matches the register on every edge
  // without an extra cycle of delay
  // status mirror for the core's fault handling
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      O_AUX_FAULT_STATUS <= AUX_FAULT_RESET;
    end else if (I_CE) begin
      O_AUX_FAULT_STATUS <= aux_fault_next;
    end
  end

  // outputs come straight from flip-flops
  // and carry no logic of their own
  assign O_WB_DAT = rdata_reg;
  assign O_WB_ACK = ack_reg;
  assign O_WB_ERR = err_reg;

  // hazards worth knowing:
  // - a write to the status word with lane
  //   selects off clears nothing in that lane
  // - an unprivileged write to any privileged
  //   word is answered with err and dropped
  // - writes to read-only words are acked so
  //   that software sees no bus fault there
  // - the bus error qualifiers of each group
  //   live outside; flags are kept regardless
  // - reset clears both select copies and all
  //   fault flags at once, without the clock

endmodule : fault_id_regs

// >>> design/fault_id_pkg.sv
// Purpose: shared constants and carriers for the fault status and cache id bank
// Assumes: 32-bit classic Wishbone with byte addressing, one clock domain
// Notes:   every offset, field position and fixed value of the bank lives here
package fault_id_pkg;

  // register byte addresses
  localparam logic [31:0] ADDR_CORE_IDENTITY_BASE = 32'he000ed00;
  localparam logic [31:0] ADDR_AUX_FAULT_STATUS   = 32'he000ed3c;
  localparam logic [31:0] ADDR_CACHE_LEVEL_ID     = 32'he000ed78;
  localparam logic [31:0] ADDR_CACHE_TYPE         = 32'he000ed7c;
  localparam logic [31:0] ADDR_CACHE_SIZE_INFO    = 32'he000ed80;
  localparam logic [31:0] ADDR_CACHE_SIZE_SELECT  = 32'he000ed84;

  // aux fault status bit positions
  localparam int BIT_FETCH_GATE    = 29;
  localparam int BIT_FETCH_ECC     = 28;
  localparam int BIT_FETCH_KIND    = 27;
  localparam int BIT_FETCH_MAXI    = 24;
  localparam int BIT_FETCH_DTCM    = 22;
  localparam int BIT_FETCH_ITCM    = 21;
  localparam int BIT_PREC_POISON   = 19;
  localparam int BIT_PREC_GATE     = 18;
  localparam int BIT_PREC_ECC      = 17;
  localparam int BIT_PREC_KIND     = 16;
  localparam int BIT_PREC_IPPB     = 15;
  localparam int BIT_PREC_EPPB     = 14;
  localparam int BIT_PREC_MAXI     = 13;
  localparam int BIT_PREC_PAHB     = 12;
  localparam int BIT_PREC_DTCM     = 11;
  localparam int BIT_PREC_ITCM     = 10;
  localparam int BIT_IMPR_POISON   = 9;
  localparam int BIT_IMPR_ECC      = 7;
  localparam int BIT_IMPR_KIND     = 6;
  localparam int BIT_IMPR_EPPB     = 4;
  localparam int BIT_IMPR_MAXI     = 3;
  localparam int BIT_IMPR_PAHB     = 2;
  localparam int BIT_IMPR_DTCM     = 1;
  localparam int BIT_IMPR_ITCM     = 0;
  localparam logic [31:0] AUX_FAULT_RESET = 32'h0000_0000;

  // cache level id fields
  localparam int             CLID_UU_LSB    = 27;
  localparam int             CLID_COH_LSB   = 24;
  localparam int             CLID_UIS_LSB   = 21;
  localparam logic [2:0]     LEVEL_NONE     = 3'h0;
  localparam logic [2:0]     LEVEL_ONE      = 3'h1;
  localparam logic [2:0]     KIND_NONE      = 3'h0;
  localparam logic [2:0]     KIND_INSTR     = 3'h1;
  localparam logic [2:0]     KIND_DATA      = 3'h2;
  localparam logic [2:0]     KIND_BOTH      = 3'h3;

  // cache type and cache size info layout
  localparam logic [31:0] CACHE_TYPE_VALUE = 32'h8303c003;
  localparam logic [3:0]  CSI_POLICY_BITS  = 4'hf;   // write-through, write-back, ra, wa
  localparam logic [9:0]  CSI_ASSOC_INSTR  = 10'h001;
  localparam logic [9:0]  CSI_ASSOC_DATA   = 10'h003;
  localparam logic [2:0]  CSI_LINE_SIZE    = 3'h1;
  localparam int          CSI_SETS_W       = 15;
  localparam logic        SELECT_RESET     = 1'b0;

  // classic wishbone request from the master
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [31:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_s;

  // one cycle fault reports from the core's bus interfaces
  typedef struct packed {
    logic fetch_gate_violation;
    logic fetch_uncorrectable_error;
    logic fetch_main_axi_fault;
    logic fetch_axi_resp_kind;
    logic fetch_data_tcm_fault;
    logic fetch_instr_tcm_fault;
    logic precise_poisoned_read;
    logic precise_gate_violation;
    logic precise_uncorrectable_error;
    logic precise_axi_resp_kind;
    logic precise_internal_periph_fault;
    logic precise_external_periph_fault;
    logic precise_main_axi_fault;
    logic precise_periph_ahb_fault;
    logic precise_data_tcm_fault;
    logic precise_instr_tcm_fault;
    logic imprecise_poisoned_read;
    logic imprecise_uncorrectable_error;
    logic imprecise_axi_resp_kind;
    logic imprecise_external_periph_fault;
    logic imprecise_main_axi_fault;
    logic imprecise_periph_ahb_fault;
    logic imprecise_data_tcm_fault;
    logic imprecise_instr_tcm_fault;
  } fault_event_s;

endpackage : fault_id_pkg

// >>> bench/fault_id_regs_props.sv
// Purpose: concurrent checks on the fault status and cache id bank ports
// Assumes: one clock domain, asynchronous active high reset
// Notes:   bound into every instance of fault_id_regs
module fault_id_regs_chk
  import fault_id_pkg::*;
(
  input wire logic         I_CLOCK,
  input wire logic         I_RST,
  input wire logic         I_CE,
  input wire wb_req_s      I_WB_REQ,
  input wire logic         I_WB_PRIV,
  input wire logic         I_WB_SECURE,
  input wire fault_event_s I_FAULT_EVENT,
  input wire logic [31:0]  O_WB_DAT,
  input wire logic         O_WB_ACK,
  input wire logic         O_WB_ERR,
  input wire logic [31:0]  O_AUX_FAULT_STATUS
);
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_RST);
  // a request is only taken while no answer is standing
  logic taken;
  assign taken = I_CE && I_WB_REQ.cyc && I_WB_REQ.stb && !O_WB_ACK && !O_WB_ERR;
  ack_single_pulse_a: assert property (O_WB_ACK |=> !O_WB_ACK) else $error("ack longer than one cycle");
  answer_one_kind_a: assert property (!(O_WB_ACK && O_WB_ERR)) else $error("ack and err together");
  answer_next_cycle_a: assert property (taken |=> O_WB_ACK || O_WB_ERR) else $error("no answer");
  idle_data_zero_a: assert property (!O_WB_ACK |-> O_WB_DAT == 32'h0) else $error("data outside ack");
  type_read_value_a: assert property (taken && !I_WB_REQ.we && I_WB_REQ.adr == ADDR_CACHE_TYPE
    |=> O_WB_ACK && O_WB_DAT == CACHE_TYPE_VALUE) else $error("cache type value wrong");
  unpriv_level_err_a: assert property (taken && !I_WB_PRIV && I_WB_REQ.adr == ADDR_CACHE_LEVEL_ID
    |=> O_WB_ERR) else $error("unprivileged level access answered");
  prec_maxi_set_a: assert property (I_CE && I_FAULT_EVENT.precise_main_axi_fault
    |=> O_AUX_FAULT_STATUS[13]) else $error("precise main axi flag not set");
  prec_kind_load_a: assert property (I_CE && I_FAULT_EVENT.precise_main_axi_fault
    |=> O_AUX_FAULT_STATUS[16] == $past(I_FAULT_EVENT.precise_axi_resp_kind)) else $error("kind");
  reserved_flags_zero_a: assert property ({O_AUX_FAULT_STATUS[31:30], O_AUX_FAULT_STATUS[26:25],
    O_AUX_FAULT_STATUS[23], O_AUX_FAULT_STATUS[20], O_AUX_FAULT_STATUS[8], O_AUX_FAULT_STATUS[5]}
    == 8'h0) else $error("reserved status bit set");
  status_hold_a: assert property (I_CE && !(I_WB_REQ.cyc && I_WB_REQ.we) && I_FAULT_EVENT == '0
    |=> $stable(O_AUX_FAULT_STATUS)) else $error("status changed without cause");
endmodule : fault_id_regs_chk

bind fault_id_regs fault_id_regs_chk chk (.I_CLOCK(I_CLOCK), .I_RST(I_RST), .I_CE(I_CE),
  .I_WB_REQ(I_WB_REQ), .I_WB_PRIV(I_WB_PRIV), .I_WB_SECURE(I_WB_SECURE),
  .I_FAULT_EVENT(I_FAULT_EVENT), .O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK),
  .O_WB_ERR(O_WB_ERR), .O_AUX_FAULT_STATUS(O_AUX_FAULT_STATUS));

// >>> bench/testbench.sv
// Purpose: directed checks of the fault status and cache id bank over Wishbone
// Assumes: answer within a few cycles; clock enable held high throughout
// Notes:   identity codes are arbitrary values chosen for this bench
module testbench;
  import fault_id_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [14:0] I_SETS = 15'h00ff;
  localparam logic [14:0] D_SETS = 15'h007f;
  localparam logic [31:0] IDENT  = 32'h5a17_1234;  // arbitrary value
  localparam logic [31:0] INFO_I = {CSI_POLICY_BITS, I_SETS, CSI_ASSOC_INSTR, CSI_LINE_SIZE};
  localparam logic [31:0] INFO_D = {CSI_POLICY_BITS, D_SETS, CSI_ASSOC_DATA, CSI_LINE_SIZE};
  logic         clock = 1'b0;
  logic         rst   = 1'b1;
  logic         ce    = 1'b1;
  wb_req_s      req   = '0;
  logic         priv  = 1'b0;
  logic         sec   = 1'b0;
  fault_event_s ev    = '0;
  logic [31:0]  dat, aux;
  logic         ack, err;
  int           n_mismatch = 0;
  int           num_checks = 0;
  fault_id_regs #(.ICACHE_SETS(I_SETS), .DCACHE_SETS(D_SETS), .IMPLEMENTER_CODE(8'h5a),
    .VARIANT_CODE(4'h1), .ARCH_CODE(4'h7), .PART_NUMBER_CODE(12'h123), .REVISION_CODE(4'h4))
    dut (.I_CLOCK(clock), .I_RST(rst), .I_CE(ce), .I_WB_REQ(req), .I_WB_PRIV(priv),
    .I_WB_SECURE(sec), .I_FAULT_EVENT(ev), .O_WB_DAT(dat), .O_WB_ACK(ack), .O_WB_ERR(err),
    .O_AUX_FAULT_STATUS(aux));
  // free running 100 MHz clock
  always #5 clock = ~clock;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one classic cycle; reads of ack, err and data see the values of the sampling edge
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic p, input logic sc, input logic [31:0] q_exp,
                     input logic e_exp);
    int n;
    n = 0;
    @(posedge clock);
    req  <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: s, dat: d};
    priv <= p;
    sec  <= sc;
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
    if (n >= 20) n_mismatch++;
    if (!w) chk(dat, q_exp);
    chk({31'h0, err}, {31'h0, e_exp});
    req <= '0;
  endtask : bus
  task automatic rd(input logic [31:0] a, input logic [31:0] q, input logic p = 1'b1,
                    input logic sc = 1'b0, input logic e = 1'b0);
    bus(1'b0, a, 32'h0, 4'hf, p, sc, q, e);
  endtask : rd
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf,
                    input logic p = 1'b1, input logic sc = 1'b0, input logic e = 1'b0);
    bus(1'b1, a, d, s, p, sc, 32'h0, e);
  endtask : wr
  task automatic pulse(input fault_event_s f);
    @(posedge clock);
    ev <= f;
    @(posedge clock);
    ev <= '0;
  endtask : pulse
  task automatic t_reset;
    rd(ADDR_CORE_IDENTITY_BASE, IDENT);
    rd(ADDR_CACHE_TYPE, CACHE_TYPE_VALUE);
    rd(ADDR_AUX_FAULT_STATUS, AUX_FAULT_RESET);
    rd(ADDR_CACHE_SIZE_SELECT, 32'h0);
    rd(ADDR_CACHE_LEVEL_ID, 32'h0920_0003);
    rd(ADDR_CACHE_SIZE_INFO, INFO_D);
    $display("test reset values done");
  endtask : t_reset
  // each cause sets exactly its own flag; kind bits only load beside a main axi fault
  task automatic t_flags;
    int pos[24] = '{29, 28, 24, 27, 22, 21, 19, 18, 17, 16, 15, 14, 13, 12, 11, 10,
                    9, 7, 6, 4, 3, 2, 1, 0};
    int kmain[3] = '{2, 12, 20};
    int kind[3] = '{3, 9, 18};
    for (int k = 0; k < 24; k++) begin
      pulse(fault_event_s'(24'h1 << (23 - k)));
      if (k == 3 || k == 9 || k == 18) rd(ADDR_AUX_FAULT_STATUS, 32'h0);
      else rd(ADDR_AUX_FAULT_STATUS, 32'h1 << pos[k]);
      chk(aux, (k == 3 || k == 9 || k == 18) ? 32'h0 : 32'h1 << pos[k]);
      wr(ADDR_AUX_FAULT_STATUS, 32'hffff_ffff);
    end
    for (int g = 0; g < 3; g++) begin
      pulse(fault_event_s'((24'h1 << (23 - kmain[g])) | (24'h1 << (23 - kind[g]))));
      rd(ADDR_AUX_FAULT_STATUS, (32'h1 << pos[kmain[g]]) | (32'h1 << pos[kind[g]]));
      pulse(fault_event_s'(24'h1 << (23 - kmain[g])));
      rd(ADDR_AUX_FAULT_STATUS, 32'h1 << pos[kmain[g]]);
      wr(ADDR_AUX_FAULT_STATUS, 32'hffff_ffff);
      rd(ADDR_AUX_FAULT_STATUS, 32'h0);
    end
    $display("test fault flags done");
  endtask : t_flags
  // clearing respects the written ones and the byte lanes; refused writes leave flags
  task automatic t_clear;
    pulse(fault_event_s'(24'h1 << (23 - 7) | 24'h1 << (23 - 23)));
    wr(ADDR_AUX_FAULT_STATUS, 32'hffff_ffff, 4'hf, 1'b0, 1'b0, 1'b1);
    wr(ADDR_AUX_FAULT_STATUS, 32'h0004_0001, 4'h1);
    rd(ADDR_AUX_FAULT_STATUS, 32'h0004_0000);
    chk(aux, 32'h0004_0000);
    wr(ADDR_AUX_FAULT_STATUS, 32'h0004_0000);
    $display("test clearing done");
  endtask : t_clear
  task automatic t_select;
    wr(ADDR_CACHE_SIZE_SELECT, 32'hffff_ffff, 4'hf, 1'b1, 1'b1);
    rd(ADDR_CACHE_SIZE_INFO, INFO_I, 1'b1, 1'b1);
    rd(ADDR_CACHE_SIZE_SELECT, 32'h1, 1'b1, 1'b1);
    rd(ADDR_CACHE_SIZE_INFO, INFO_I, 1'b1, 1'b1);
    rd(ADDR_CACHE_SIZE_SELECT, 32'h0, 1'b1, 1'b0);
    rd(ADDR_CACHE_SIZE_INFO, INFO_D, 1'b1, 1'b0);
    wr(ADDR_CACHE_SIZE_SELECT, 32'h0, 4'he, 1'b1, 1'b1);
    rd(ADDR_CACHE_SIZE_SELECT, 32'h1, 1'b1, 1'b1);
    wr(ADDR_CACHE_SIZE_SELECT, 32'h1, 4'hf, 1'b0, 1'b0, 1'b1);
    rd(ADDR_CACHE_SIZE_SELECT, 32'h0);
    $display("test size select done");
  endtask : t_select
  task automatic t_refuse;
    rd(ADDR_CACHE_LEVEL_ID, 32'h0, 1'b0, 1'b0, 1'b1);
    rd(ADDR_CACHE_SIZE_INFO, 32'h0, 1'b0, 1'b0, 1'b1);
    rd(ADDR_AUX_FAULT_STATUS, 32'h0, 1'b0, 1'b0, 1'b1);
    rd(32'he000ed88, 32'h0, 1'b1, 1'b0, 1'b1);
    rd(ADDR_CORE_IDENTITY_BASE, IDENT, 1'b0);
    wr(ADDR_CORE_IDENTITY_BASE, 32'h0);
    rd(ADDR_CORE_IDENTITY_BASE, IDENT);
    wr(ADDR_CACHE_TYPE, 32'h0);
    rd(ADDR_CACHE_TYPE, CACHE_TYPE_VALUE, 1'b0);
    wr(ADDR_CACHE_LEVEL_ID, 32'hffff_ffff);
    rd(ADDR_CACHE_LEVEL_ID, 32'h0920_0003);
    $display("test refusals done");
  endtask : t_refuse
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude
  // main sequence after twelve cycles of reset
  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_flags();
    t_clear();
    t_select();
    t_refuse();
    conclude();
  end
  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    #200000;
    n_mismatch++;
    conclude();
  end
endmodule : testbench
